// [shared/fspc_pkg.sv]
// constants of the flash self-programming controller
package fspc_pkg;
   // register offsets on the plain register port
   localparam logic [7:0] ADDR_LOW_OFS = 8'hA6;
   localparam logic [7:0] ADDR_HIGH_OFS = 8'hA7;
   localparam logic [7:0] COMMAND_OFS = 8'hAF;
   // offsets without a printed address
   localparam logic [7:0] DATA_OFS = 8'hA8;
   localparam logic [7:0] ENABLE_OFS = 8'hA9;
   localparam logic [7:0] TRIGGER_OFS = 8'hAA;
   localparam logic [7:0] STATUS_OFS = 8'hAB;
   // reset values
   localparam logic [7:0] COMMAND_RST = 8'h30;
   localparam logic [7:0] ADDR_HIGH_RST = 8'h00;
   localparam logic [7:0] ADDR_LOW_RST = 8'h00;
   localparam logic [7:0] DATA_RST = 8'hFF;
   localparam logic ENABLE_N_RST = 1'b1;
   // command field positions
   localparam int REGION_HI_POS = 7;
   localparam int REGION_LO_POS = 6;
   localparam int OPER_FLAG_POS = 5;
   localparam int CYCLE_FLAG_POS = 4;
   localparam int CTRL_MSB = 3;
   // trigger key and status bit positions
   localparam logic [7:0] TRIGGER_KEY = 8'h01;
   localparam int STAT_BUSY_POS = 0;
   localparam int STAT_FAIL_POS = 1;
   localparam int STAT_OSC_POS = 2;
   // command codes
   localparam logic [7:0] CMD_READ_ID = 8'h0C;
   localparam logic [7:0] CMD_PAGE_ERASE = 8'h22;
   localparam logic [7:0] CMD_PROGRAM = 8'h21;
   localparam logic [7:0] CMD_READ = 8'h00;
   localparam logic [7:0] CMD_CFG_ERASE = 8'hE2;
   localparam logic [7:0] CMD_CFG_PROGRAM = 8'hE1;
   localparam logic [15:0] CFG_LAST_ADDR = 16'h0003;
   // timing
   localparam int CLK_MHZ = 125;
   localparam int READ_NS = 40;
   localparam int PROG_US = 30;
   localparam int ERASE_US = 5000;
   localparam int OSC_START_NS = 100;
   localparam int READ_CYC = (READ_NS * CLK_MHZ + 999) / 1000;
   localparam int PROG_CYC = PROG_US * CLK_MHZ;
   localparam int ERASE_CYC = ERASE_US * CLK_MHZ;
   localparam int OSC_START_CYC = (OSC_START_NS * CLK_MHZ + 999) / 1000;
   // sequencer states
   typedef enum logic [2:0] {
      FSPC_IDLE = 3'b000,
      FSPC_WAKE = 3'b001,
      FSPC_RUN = 3'b011,
      FSPC_DONE = 3'b010
   } fspc_state_t;
   // operation kinds
   typedef enum logic [2:0] {
      FSPC_OP_NONE,
      FSPC_OP_ID,
      FSPC_OP_ERASE,
      FSPC_OP_PROG,
      FSPC_OP_READ
   } fspc_op_t;
endpackage

// [hw/fspc_timer.sv]
// down counter that times one flash operation
`timescale 1ns/1ps
module fspc_timer
   import fspc_pkg::*;
#(
   parameter int WIDTH = 20
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic load,
   input wire logic [WIDTH-1:0] count,
   output logic expired
);
   initial begin
      if (WIDTH < 2) begin
         $error("fspc_timer width too small");
      end
   end
   logic [WIDTH-1:0] remain_ff;
   logic running_ff;
   // load then count down to one, pulse expired at end
   always_ff @(posedge core_clk) begin
      if (rst) begin
         remain_ff <= '0;
         running_ff <= 1'b0;
      end else if (load) begin
         remain_ff <= count;
         running_ff <= 1'b1;
      end else if (running_ff) begin
         remain_ff <= remain_ff - WIDTH'(1);
         if (remain_ff <= WIDTH'(1)) begin
            running_ff <= 1'b0;
         end
      end
   end
   assign expired = running_ff && (remain_ff <= WIDTH'(1));
endmodule

// [hw/fspc_osc_ctrl.sv]
// gate for the timing oscillator and its start-up wait
`timescale 1ns/1ps
module fspc_osc_ctrl
   import fspc_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic enable_n,
   output logic osc_run,
   output logic osc_ready
);
   logic [7:0] settle_ff;
   // oscillator runs only while enable is low
   always_ff @(posedge core_clk) begin
      if (rst) begin
         osc_run <= 1'b0;
      end else begin
         osc_run <= ~enable_n;
      end
   end
   // start-up settling count
   always_ff @(posedge core_clk) begin
      if (rst || !osc_run) begin
         settle_ff <= '0;
      end else if (settle_ff < 8'(OSC_START_CYC)) begin
         settle_ff <= settle_ff + 8'h01;
      end
   end
   assign osc_ready = osc_run && (settle_ff >= 8'(OSC_START_CYC));
endmodule

// [hw/flash_self_programming_ctrl.sv]
// flash self-programming controller top with register port and sequencer
//
// Decided for this implementation: strobed register access.
`timescale 1ns/1ps
module flash_self_programming_ctrl
   import fspc_pkg::*;
#(
   parameter int FLASH_AW = 16,
   parameter logic [15:0] DEVICE_ID = 16'hA5C3, // arbitrary value
   parameter int ERASE_CYCLES = ERASE_CYC
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWdata,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [7:0] regRdata,
   output logic busy,
   output logic oscEnable,
   output logic flashRegion,
   output logic [FLASH_AW-1:0] flashAddr,
   output logic [7:0] flashWdata,
   output logic flashRead,
   output logic flashProgram,
   output logic flashErase,
   input wire logic [7:0] flashRdata
);
   initial begin
      if (FLASH_AW != 16) begin
         $error("flash address width must be 16");
      end
      if (ERASE_CYCLES < 2 || ERASE_CYCLES >= (1 << 20)) begin
         $error("erase cycle count out of range");
      end
   end

   ////////////////////////////////////////////////////////////////////
   // register file
   logic [7:0] command_ff;
   logic [7:0] addrHigh_ff;
   logic [7:0] addrLow_ff;
   logic [7:0] data_ff;
   logic enableN_ff;
   logic fail_ff;
   logic busy_ff;
   fspc_state_t state_ff;
   fspc_op_t op_ff;
   fspc_op_t reqOp;
   logic oscRun;
   logic oscReady;
   logic timerLoad;
   logic timerDone;
   logic [19:0] timerCount;
   logic opDone;
   logic trigger;

   assign trigger = regWrite && regAddr == TRIGGER_OFS && regWdata == TRIGGER_KEY;

   // software writes; frozen while an operation is in flight
   always_ff @(posedge core_clk) begin
      if (rst) begin
         command_ff <= COMMAND_RST;
         addrHigh_ff <= ADDR_HIGH_RST;
         addrLow_ff <= ADDR_LOW_RST;
      end else if (regWrite && !busy_ff) begin
         unique case (regAddr)
            COMMAND_OFS: command_ff <= regWdata;
            ADDR_HIGH_OFS: addrHigh_ff <= regWdata;
            ADDR_LOW_OFS: addrLow_ff <= regWdata;
            default: ;
         endcase
      end
   end

   // enable write; also taken while waking so that a disable aborts
   always_ff @(posedge core_clk) begin
      if (rst) begin
         enableN_ff <= ENABLE_N_RST;
      end else if (regWrite && regAddr == ENABLE_OFS && (!busy_ff || state_ff == FSPC_WAKE)) begin
         enableN_ff <= regWdata[0];
      end
   end

   // command decode into an operation kind
   function automatic fspc_op_t decode_op(input logic [7:0] cmd, input logic [15:0] adr);
      fspc_op_t op;
      op = FSPC_OP_NONE;
      unique case (cmd)
         CMD_READ_ID: if (adr <= 16'h0001) op = FSPC_OP_ID;
         CMD_PAGE_ERASE: op = FSPC_OP_ERASE;
         CMD_PROGRAM: op = FSPC_OP_PROG;
         CMD_READ: op = FSPC_OP_READ;
         CMD_CFG_ERASE: if (adr == 16'h0000) op = FSPC_OP_ERASE;
         CMD_CFG_PROGRAM: if (adr <= CFG_LAST_ADDR) op = FSPC_OP_PROG;
         default: op = FSPC_OP_NONE;
      endcase
      return op;
   endfunction

   // operation that a trigger in this cycle would start
   assign reqOp = decode_op(command_ff, {addrHigh_ff, addrLow_ff});

   ////////////////////////////////////////////////////////////////////
   // oscillator and operation timer
   fspc_osc_ctrl u_osc (
      .core_clk(core_clk),
      .rst(rst),
      .enable_n(enableN_ff),
      .osc_run(oscRun),
      .osc_ready(oscReady)
   );

   fspc_timer #(
      .WIDTH(20)
   ) u_timer (
      .core_clk(core_clk),
      .rst(rst),
      .load(timerLoad),
      .count(timerCount),
      .expired(timerDone)
   );

   // duration for the current operation
   always_comb begin
      unique case (op_ff)
         FSPC_OP_ERASE: timerCount = 20'(ERASE_CYCLES);
         FSPC_OP_PROG: timerCount = 20'(PROG_CYC);
         default: timerCount = 20'(READ_CYC);
      endcase
   end

   ////////////////////////////////////////////////////////////////////
   // sequencer
   assign timerLoad = (state_ff == FSPC_WAKE) && oscReady;
   assign opDone = (state_ff == FSPC_RUN) && timerDone;

   // state walk: idle, wake oscillator, run, done
   always_ff @(posedge core_clk) begin
      if (rst) begin
         state_ff <= FSPC_IDLE;
         op_ff <= FSPC_OP_NONE;
      end else begin
         unique case (state_ff)
            FSPC_IDLE: begin
               if (trigger && !enableN_ff) begin
                  op_ff <= reqOp;
                  if (reqOp != FSPC_OP_NONE) begin
                     state_ff <= FSPC_WAKE;
                  end
               end
            end
            FSPC_WAKE: begin
               if (enableN_ff) begin
                  state_ff <= FSPC_IDLE;
               end else if (oscReady) begin
                  state_ff <= FSPC_RUN;
               end
            end
            FSPC_RUN: if (timerDone) state_ff <= FSPC_DONE;
            FSPC_DONE: state_ff <= FSPC_IDLE;
            default: state_ff <= FSPC_IDLE;
         endcase
      end
   end

   // busy from trigger until data register is valid
   always_ff @(posedge core_clk) begin
      if (rst) begin
         busy_ff <= 1'b0;
      end else if (state_ff == FSPC_IDLE && trigger && !enableN_ff &&
                   reqOp != FSPC_OP_NONE) begin
         busy_ff <= 1'b1;
      end else if (state_ff == FSPC_DONE || (state_ff == FSPC_WAKE && enableN_ff)) begin
         busy_ff <= 1'b0;
      end
   end

   // sticky fail on a refused trigger; set wins over clear
   always_ff @(posedge core_clk) begin
      if (rst) begin
         fail_ff <= 1'b0;
      end else if (state_ff == FSPC_IDLE && trigger &&
                   (enableN_ff || reqOp == FSPC_OP_NONE)) begin
         fail_ff <= 1'b1;
      end else if (regWrite && regAddr == STATUS_OFS && regWdata[STAT_FAIL_POS]) begin
         fail_ff <= 1'b0;
      end
   end

   // data register: software write or read result
   always_ff @(posedge core_clk) begin
      if (rst) begin
         data_ff <= DATA_RST;
      end else if (opDone && op_ff == FSPC_OP_ID) begin
         data_ff <= addrLow_ff[0] ? DEVICE_ID[15:8] : DEVICE_ID[7:0];
      end else if (opDone && op_ff == FSPC_OP_READ) begin
         data_ff <= flashRdata;
      end else if (regWrite && regAddr == DATA_OFS && !busy_ff) begin
         data_ff <= regWdata;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // flash array strobes, all registered
   always_ff @(posedge core_clk) begin
      if (rst) begin
         flashRead <= 1'b0;
         flashProgram <= 1'b0;
         flashErase <= 1'b0;
         flashAddr <= '0;
         flashWdata <= 8'h00;
         flashRegion <= 1'b0;
      end else begin
         flashRead <= (state_ff == FSPC_RUN) && op_ff == FSPC_OP_READ;
         flashProgram <= (state_ff == FSPC_RUN) && op_ff == FSPC_OP_PROG;
         flashErase <= (state_ff == FSPC_RUN) && op_ff == FSPC_OP_ERASE;
         flashAddr <= {addrHigh_ff, addrLow_ff};
         flashWdata <= data_ff;
         flashRegion <= command_ff[REGION_HI_POS] & command_ff[REGION_LO_POS];
      end
   end

   // outputs of busy and oscillator
   always_ff @(posedge core_clk) begin
      if (rst) begin
         busy <= 1'b0;
         oscEnable <= 1'b0;
      end else begin
         busy <= busy_ff;
         oscEnable <= oscRun;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // read port, data one cycle after the strobe
   always_ff @(posedge core_clk) begin
      if (rst) begin
         regRdata <= 8'h00;
      end else if (regRead) begin
         unique case (regAddr)
            COMMAND_OFS: regRdata <= command_ff;
            ADDR_HIGH_OFS: regRdata <= addrHigh_ff;
            ADDR_LOW_OFS: regRdata <= addrLow_ff;
            DATA_OFS: regRdata <= data_ff;
            ENABLE_OFS: regRdata <= {7'h00, enableN_ff};
            STATUS_OFS: regRdata <= {5'h00, oscRun, fail_ff, busy_ff};
            default: regRdata <= 8'h00;
         endcase
      end else begin
         regRdata <= 8'h00;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // checks
   enable_osc_a: assert property (@(posedge core_clk) disable iff (rst)
      $fell(enableN_ff) |=> ##1 oscEnable)
      else $error("oscillator not started after enable");
   disable_osc_a: assert property (@(posedge core_clk) disable iff (rst)
      $rose(enableN_ff) |=> ##1 !oscEnable)
      else $error("oscillator not stopped after disable");
   trigger_only_a: assert property (@(posedge core_clk) disable iff (rst)
      $rose(busy_ff) |-> $past(trigger))
      else $error("operation began without trigger");
   id_low_a: assert property (@(posedge core_clk) disable iff (rst)
      opDone && op_ff == FSPC_OP_ID && !addrLow_ff[0] |=> data_ff == DEVICE_ID[7:0])
      else $error("identifier low byte wrong");
   read_data_a: assert property (@(posedge core_clk) disable iff (rst)
      opDone && op_ff == FSPC_OP_READ |=> data_ff == $past(flashRdata))
      else $error("read data not captured");
   program_strobe_a: assert property (@(posedge core_clk) disable iff (rst)
      state_ff == FSPC_RUN && op_ff == FSPC_OP_PROG |=> flashProgram)
      else $error("program strobe missing");
   erase_strobe_a: assert property (@(posedge core_clk) disable iff (rst)
      state_ff == FSPC_RUN && op_ff == FSPC_OP_ERASE |=> flashErase)
      else $error("erase strobe missing");
   addr_join_a: assert property (@(posedge core_clk) disable iff (rst)
      1'b1 |=> flashAddr == {$past(addrHigh_ff), $past(addrLow_ff)})
      else $error("address bytes not joined");
   cfg_region_a: assert property (@(posedge core_clk) disable iff (rst)
      command_ff == CMD_CFG_ERASE |=> flashRegion)
      else $error("configuration region not selected");
   cfg_range_a: assert property (@(posedge core_clk) disable iff (rst)
      state_ff == FSPC_IDLE && trigger && command_ff == CMD_CFG_PROGRAM &&
      {addrHigh_ff, addrLow_ff} > CFG_LAST_ADDR |=> !busy_ff)
      else $error("configuration byte beyond range accepted");
   cmd_reset_a: assert property (@(posedge core_clk) disable iff (rst)
      $past(rst) |-> command_ff[OPER_FLAG_POS] && command_ff[CYCLE_FLAG_POS])
      else $error("command reset value wrong");
   read_done_a: assert property (@(posedge core_clk) disable iff (rst)
      $rose(busy_ff) && op_ff == FSPC_OP_READ |-> ##[1:40] !busy_ff)
      else $error("read operation too long");

   id_high_a: assert property (@(posedge core_clk) disable iff (rst)
      opDone && op_ff == FSPC_OP_ID && addrLow_ff[0] |=> data_ff == DEVICE_ID[15:8])
      else $error("identifier high byte wrong");
   read_strobe_a: assert property (@(posedge core_clk) disable iff (rst)
      state_ff == FSPC_RUN && op_ff == FSPC_OP_READ |=> flashRead)
      else $error("read strobe missing");
   idle_quiet_a: assert property (@(posedge core_clk) disable iff (rst)
      state_ff == FSPC_IDLE |=> !flashRead && !flashProgram && !flashErase)
      else $error("flash strobe without operation");
   main_region_a: assert property (@(posedge core_clk) disable iff (rst)
      state_ff == FSPC_RUN && !command_ff[REGION_HI_POS] |=> !flashRegion)
      else $error("main area operation marked as configuration");
   fail_set_a: assert property (@(posedge core_clk) disable iff (rst)
      state_ff == FSPC_IDLE && trigger && enableN_ff |=> fail_ff && !busy_ff)
      else $error("trigger while disabled not refused");
   wake_abort_a: assert property (@(posedge core_clk) disable iff (rst)
      state_ff == FSPC_WAKE && enableN_ff |=> state_ff == FSPC_IDLE && !busy_ff)
      else $error("disable while waking did not abort");
   frozen_cmd_a: assert property (@(posedge core_clk) disable iff (rst)
      busy_ff && regWrite && regAddr == COMMAND_OFS |=> $stable(command_ff))
      else $error("command changed during operation");

   // cycles spent in the run state, for the duration check
   logic [19:0] runCount_ff;
   always_ff @(posedge core_clk) begin
      if (rst || state_ff != FSPC_RUN) begin
         runCount_ff <= '0;
      end else begin
         runCount_ff <= runCount_ff + 20'h00001;
      end
   end
   erase_len_a: assert property (@(posedge core_clk) disable iff (rst)
      opDone && op_ff == FSPC_OP_ERASE |-> runCount_ff == 20'(ERASE_CYCLES - 1))
      else $error("erase duration wrong");

   read_c: cover property (@(posedge core_clk) opDone && op_ff == FSPC_OP_READ);
   prog_c: cover property (@(posedge core_clk) opDone && op_ff == FSPC_OP_PROG);
   id_c: cover property (@(posedge core_clk) opDone && op_ff == FSPC_OP_ID);
   fail_c: cover property (@(posedge core_clk) $rose(fail_ff));
   abort_c: cover property (@(posedge core_clk) state_ff == FSPC_WAKE && enableN_ff);
endmodule

// [test/fspc_flash_model.sv]
// behavioural flash array and configuration bytes facing the controller
`timescale 1ns/1ps
module fspc_flash_model #(
   parameter int PAGE_BYTES = 64
) (
   input wire logic core_clk,
   input wire logic flashRegion,
   input wire logic [15:0] flashAddr,
   input wire logic [7:0] flashWdata,
   input wire logic flashRead,
   input wire logic flashProgram,
   input wire logic flashErase,
   output logic [7:0] flashRdata
);
   logic [7:0] mainMem [0:255];
   logic [7:0] cfgMem [0:3];
   logic [7:0] lastRd_ff;
   logic [15:0] progAddr_ff;
   int base;

   ////////////////////////////////////////////////////////////////////////////
   // blank array at power-up
   initial begin
      for (int i = 0; i < 256; i++) mainMem[i] = 8'hFF;
      for (int i = 0; i < 4; i++) cfgMem[i] = 8'hFF;
      lastRd_ff = 8'h00;
      progAddr_ff = 16'h0000;
   end

   // erase sets every bit of a page, program can only clear bits
   always @(posedge core_clk) begin
      base = int'(flashAddr[7:0]) / PAGE_BYTES * PAGE_BYTES;
      if (flashErase && flashRegion) begin
         for (int i = 0; i < 4; i++) cfgMem[i] = 8'hFF;
      end else if (flashErase) begin
         for (int i = 0; i < PAGE_BYTES; i++) mainMem[base + i] = 8'hFF;
      end
      if (flashProgram && flashRegion) begin
         cfgMem[flashAddr[1:0]] = cfgMem[flashAddr[1:0]] & flashWdata;
      end else if (flashProgram) begin
         mainMem[flashAddr[7:0]] = mainMem[flashAddr[7:0]] & flashWdata;
      end
      if (flashProgram) progAddr_ff = flashAddr;
      if (flashRead) lastRd_ff = flashRdata;
   end

   // read data only while a read is asked, else a changed stale value
   assign flashRdata = flashRead ? mainMem[flashAddr[7:0]] : ~lastRd_ff;
endmodule

// [test/testbench.sv]
// self-checking bench of the flash self-programming controller
`timescale 1ns/1ps
module testbench;
   import fspc_pkg::*;
   localparam int ERASE_SMALL = 20;
   localparam int TIMEOUT_CYC = 30000;
   localparam logic [15:0] ID_VAL = 16'h5AC3; // arbitrary value
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] regAddr = 8'h00;
   logic [7:0] regWdata = 8'h00;
   logic regWrite = 1'b0;
   logic regRead = 1'b0;
   logic [7:0] regRdata, flashWdata, flashRdata, rdVal;
   logic busy, oscEnable, flashRegion, flashRead, flashProgram, flashErase;
   logic [15:0] flashAddr;
   int err_total = 0;
   int total_checks = 0;
   int cycles = 0;

   ////////////////////////////////////////////////////////////////////////////
   // clock and hang guard
   always #4 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      cycles++;
      if (cycles >= TIMEOUT_CYC) begin
         err_total++;
         summarize();
      end
   end

   flash_self_programming_ctrl #(.DEVICE_ID(ID_VAL), .ERASE_CYCLES(ERASE_SMALL))
      u_flash_self_programming_ctrl (.core_clk(core_clk), .rst(rst), .regAddr(regAddr),
      .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
      .busy(busy), .oscEnable(oscEnable), .flashRegion(flashRegion), .flashAddr(flashAddr),
      .flashWdata(flashWdata), .flashRead(flashRead), .flashProgram(flashProgram),
      .flashErase(flashErase), .flashRdata(flashRdata));
   fspc_flash_model u_fspc_flash_model (.core_clk(core_clk), .flashRegion(flashRegion),
      .flashAddr(flashAddr), .flashWdata(flashWdata), .flashRead(flashRead),
      .flashProgram(flashProgram), .flashErase(flashErase), .flashRdata(flashRdata));

   ////////////////////////////////////////////////////////////////////////////
   // compare, bus cycles and one whole operation
   task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      regAddr <= a;
      regWdata <= d;
      regWrite <= 1'b1;
      @(posedge core_clk);
      regWrite <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge core_clk);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge core_clk);
      regRead <= 1'b0;
      #1 rdVal = regRdata;
   endtask
   task automatic run_op(input logic [7:0] cmd, input logic [15:0] adr, input logic [7:0] d,
                         input logic expBusy);
      wr(COMMAND_OFS, cmd);
      wr(ADDR_HIGH_OFS, adr[15:8]);
      wr(ADDR_LOW_OFS, adr[7:0]);
      wr(DATA_OFS, d);
      wr(TRIGGER_OFS, TRIGGER_KEY);
      repeat (3) @(posedge core_clk);
      #1 chk("busy after trigger", busy, expBusy);
      for (int i = 0; i < 8000 && busy !== 1'b0; i++) begin
         @(posedge core_clk);
         #1;
      end
      chk("busy cleared", busy, 1'b0);
   endtask
   task automatic chk_fail(input logic exp);
      rd(STATUS_OFS);
      chk("fail flag", rdVal[STAT_FAIL_POS], exp);
      wr(STATUS_OFS, 8'h02);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // scenarios
   task automatic t_reset();
      rd(COMMAND_OFS);
      chk("command reset", rdVal, 8'h30);
      @(posedge core_clk);
      #1 chk("read data stands one cycle", regRdata, 8'h00);
      rd(ADDR_HIGH_OFS);
      chk("addr high reset", rdVal, 8'h00);
      rd(8'hB0);
      chk("unmapped read", rdVal, 8'h00);
      chk("osc at reset", oscEnable, 1'b0);
      wr(ADDR_HIGH_OFS, 8'h12);
      wr(ADDR_LOW_OFS, 8'h34);
      wr(COMMAND_OFS, 8'hA5);
      rd(ADDR_HIGH_OFS);
      chk("addr high", rdVal, 8'h12);
      rd(ADDR_LOW_OFS);
      chk("addr low", rdVal, 8'h34);
      rd(COMMAND_OFS);
      chk("command fields", rdVal, 8'hA5);
      $display("test reset done");
   endtask
   task automatic t_enable();
      wr(ENABLE_OFS, 8'h00);
      repeat (2) @(posedge core_clk);
      #1 chk("osc on", oscEnable, 1'b1);
      repeat (OSC_START_CYC) @(posedge core_clk);
      rd(STATUS_OFS);
      chk("osc status", rdVal[STAT_OSC_POS], 1'b1);
      wr(ENABLE_OFS, 8'h01);
      repeat (3) @(posedge core_clk);
      #1 chk("osc off", oscEnable, 1'b0);
      $display("test enable done");
   endtask
   task automatic t_refused();
      run_op(CMD_READ, 16'h0010, 8'h00, 1'b0);
      chk_fail(1'b1);
      chk_fail(1'b0);
      wr(ENABLE_OFS, 8'h00);
      run_op(CMD_READ_ID, 16'h0002, 8'h00, 1'b0);
      chk_fail(1'b1);
      wr(ENABLE_OFS, 8'h01);
      $display("test refused done");
   endtask
   task automatic t_ident();
      wr(ENABLE_OFS, 8'h00);
      run_op(CMD_READ_ID, 16'h0000, 8'h00, 1'b1);
      rd(DATA_OFS);
      chk("id low", rdVal, ID_VAL[7:0]);
      run_op(CMD_READ_ID, 16'h0001, 8'h00, 1'b1);
      rd(DATA_OFS);
      chk("id high", rdVal, ID_VAL[15:8]);
      wr(ENABLE_OFS, 8'h01);
      $display("test ident done");
   endtask
   task automatic t_main();
      wr(ENABLE_OFS, 8'h00);
      run_op(CMD_PROGRAM, 16'h0134, 8'h5A, 1'b1);
      chk("program addr", u_fspc_flash_model.progAddr_ff, 16'h0134);
      chk("programmed", u_fspc_flash_model.mainMem[8'h34], 8'h5A);
      run_op(CMD_READ, 16'h0134, 8'h00, 1'b1);
      rd(DATA_OFS);
      chk("read back", rdVal, 8'h5A);
      run_op(CMD_PAGE_ERASE, 16'h0134, 8'h00, 1'b1);
      run_op(CMD_READ, 16'h0134, 8'h00, 1'b1);
      rd(DATA_OFS);
      chk("erased", rdVal, 8'hFF);
      wr(ENABLE_OFS, 8'h01);
      $display("test main area done");
   endtask
   task automatic t_config();
      wr(ENABLE_OFS, 8'h00);
      run_op(CMD_CFG_PROGRAM, 16'h0003, 8'h5A, 1'b1);
      chk("cfg byte 3", u_fspc_flash_model.cfgMem[3], 8'h5A);
      chk("main untouched", u_fspc_flash_model.mainMem[3], 8'hFF);
      run_op(CMD_CFG_ERASE, 16'h0000, 8'h00, 1'b1);
      chk("cfg erased", u_fspc_flash_model.cfgMem[3], 8'hFF);
      run_op(CMD_CFG_PROGRAM, 16'h0004, 8'h00, 1'b0);
      chk_fail(1'b1);
      wr(ENABLE_OFS, 8'h01);
      $display("test config done");
   endtask
   task automatic t_abort();
      wr(COMMAND_OFS, CMD_READ);
      wr(DATA_OFS, 8'h3C);
      wr(ENABLE_OFS, 8'h00);
      wr(TRIGGER_OFS, TRIGGER_KEY);
      @(posedge core_clk);
      #1 chk("busy while waking", busy, 1'b1);
      wr(COMMAND_OFS, CMD_PROGRAM);
      wr(ENABLE_OFS, 8'h01);
      repeat (3) @(posedge core_clk);
      #1 chk("busy after abort", busy, 1'b0);
      chk("osc after abort", oscEnable, 1'b0);
      chk_fail(1'b0);
      rd(COMMAND_OFS);
      chk("command frozen", rdVal, CMD_READ);
      rd(DATA_OFS);
      chk("data kept", rdVal, 8'h3C);
      $display("test abort done");
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // verdict and main sequence
   task automatic summarize();
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   initial begin
      repeat (12) @(posedge core_clk);
      rst <= 1'b0;
      t_reset();
      t_enable();
      t_refused();
      t_ident();
      t_main();
      t_config();
      t_abort();
      summarize();
   end
endmodule
